// ===== hdl/lsr_pkg.sv
/*
  Constants for the latency-tolerance and L1 PM substates register slice:
  offsets, field positions, reset values and widths.
  Assumes dword-aligned 12-bit configuration addresses.
*/
package lsr_pkg;

  // register offsets (byte addresses in configuration space)
  localparam logic [11:0] OFF_LATENCY  = 12'h234;
  localparam logic [11:0] OFF_CAP_HDR  = 12'h240;
  localparam logic [11:0] OFF_CAP      = 12'h244;
  localparam logic [11:0] OFF_CTRL1    = 12'h248;
  localparam logic [11:0] OFF_CTRL2    = 12'h24C;
  localparam logic [11:0] OFF_LTSSM    = 12'h33C;
  localparam logic [11:0] OFF_SLOT     = 12'h340;

  // latency register fields
  localparam int unsigned LTR_VAL_W     = 10;
  localparam int unsigned LTR_SCL_W     = 3;
  localparam int unsigned SNP_VAL_LSB   = 0;
  localparam int unsigned SNP_SCL_LSB   = 10;
  localparam int unsigned NSNP_VAL_LSB  = 16;
  localparam int unsigned NSNP_SCL_LSB  = 26;
  localparam logic [9:0]  RST_LTR_VAL   = 10'h000;
  localparam logic [2:0]  RST_LTR_SCL   = 3'h0;

  // effective latency: value times 32 to the power of scale, in ns
  localparam int unsigned LTR_NS_W      = 35;
  localparam logic [2:0]  LTR_SCALE_MAX = 3'h5;

  // extended capability header
  localparam logic [15:0] CAP_ID        = 16'h001E;
  localparam logic [3:0]  CAP_VER       = 4'h1;
  localparam logic [11:0] CAP_NEXT      = 12'h000;
  localparam logic [31:0] CAP_HDR_VALUE = {CAP_NEXT, CAP_VER, CAP_ID};

  // substates capability bits
  localparam int unsigned CAP_W         = 5;
  localparam int unsigned CAP_PM_BIT    = 1;
  localparam int unsigned CAP_ASPM_BIT  = 3;
  localparam int unsigned CAP_SUBST_BIT = 4;
  localparam logic [4:0]  CAP_MASK      = 5'h1A;
  localparam logic [4:0]  RST_CAP       = 5'h12;

  // substates control 1 and 2
  localparam int unsigned CTRL_PM_BIT   = 1;
  localparam int unsigned CTRL_ASPM_BIT = 3;
  localparam logic        RST_CTRL_EN   = 1'h0;
  localparam logic [31:0] CTRL2_VALUE   = 32'h0000_0000;

  // vendor status words
  localparam int unsigned LTSSM_W       = 8;
  localparam logic [7:0]  RST_LTSSM     = 8'h00;
  localparam logic [7:0]  LTSSM_MASK    = 8'hFF;
  localparam int unsigned SLOT_W        = 16;
  localparam logic [15:0] RST_SLOT      = 16'h0000;
  localparam logic [15:0] SLOT_MASK     = 16'hFFFF;

endpackage

// ===== hdl/lsr_ro_word.sv
/*
  Read-only word whose default can be replaced by the management path
  (SMBus, I2C or EEPROM autoload). Configuration writes never reach it.
  Assumes the management load strobe is on the core clock.
*/
`timescale 1ns/1ps
module lsr_ro_word #(
  parameter int unsigned W    = 8,
  parameter logic [11:0] ADDR = 12'h000,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] MASK = '1
) (
  input  wire logic          sys_clk_i,
  input  wire logic          nrst_i,
  input  wire logic          ld_i,
  input  wire logic [11:0]   ld_addr_i,
  input  wire logic [31:0]   ld_data_i,
  output logic      [W-1:0]  val_o
);

  typedef struct packed {
    logic [W-1:0] val;
  } lsr_ro_state_t;

  lsr_ro_state_t cur;
  lsr_ro_state_t next_cur;

  always_comb begin
    next_cur = cur;
    // reserved positions stay zero whatever is loaded
    if (ld_i && (ld_addr_i[11:2] == ADDR[11:2])) begin
      next_cur.val = ld_data_i[W-1:0] & MASK;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur.val <= RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign val_o = cur.val;

endmodule

// ===== hdl/lsr_ltr_scale.sv
/*
  Converts a latency value and scale code into nanoseconds.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
module lsr_ltr_scale (
  input  wire logic [9:0]  val_i,
  input  wire logic [2:0]  scale_i,
  output logic      [34:0] ns_o
);

  logic [5:0] shift;

  always_comb begin
    // 32^scale is a left shift by five times the scale
    shift = 6'({scale_i, 2'h0}) + 6'(scale_i);
    ns_o  = 35'h0;
    // codes above five are not permitted and give zero
    if (scale_i <= lsr_pkg::LTR_SCALE_MAX) begin
      ns_o = {25'h0, val_i} << shift;
    end
  end

endmodule

// ===== hdl/lsr_ltr_l1_regs.sv
/*
  Latency tolerance limits and L1 PM substates register slice of a
  switch upstream port, with two vendor status words.
  Assumes a single-cycle configuration request port on the core clock
  and a management load strobe (SMBus, I2C, EEPROM) on the same clock.
*/
`timescale 1ns/1ps
//
// Contract
// R1 - 10-bit snoop latency value, bits 9:0, writable, resets to zero.
// R2 - 3-bit snoop latency scale, bits 12:10, writable, resets to zero.
// R3 - 10-bit no-snoop latency value, bits 25:16, writable, resets to zero.
// R4 - 3-bit no-snoop latency scale, bits 28:26, writable, resets to zero.
// R5 - latency bits 15:13 and 31:29 read zero; writes ignored.
// R6 - capability header bits 15:0 read 001Eh.
// R7 - capability header bits 19:16 read version 1h.
// R8 - next-capability pointer bits 31:20 reads zero, list ends here.
// R9 - PCI-PM L1.1 supported, read-only bit 1, resets to one.
// R10 - ASPM L1.1 supported, read-only bit 3, resets to zero.
// R11 - L1 PM substates supported, read-only bit 4, resets to one.
// R12 - support defaults replaceable by management path, never by configuration writes.
// R13 - control 1 bit 1 is PCI-PM L1.1 enable, cleared at reset.
// R14 - control 1 bit 3 is ASPM L1.1 enable, cleared at reset.
// R15 - 8-bit read-only link training word, resets zero, management loadable.
// R16 - 16-bit read-only slot change word, resets zero, management loadable.
// R17 - effective latency is value times 32 to the power of scale, ns.
module lsr_ltr_l1_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic             cfg_ack_o,
  output logic             cfg_miss_o,
  output logic      [31:0] cfg_rdata_o,
  input  wire logic        mgmt_ld_i,
  input  wire logic [11:0] mgmt_addr_i,
  input  wire logic [31:0] mgmt_data_i,
  output logic             pm_l11_en_o,
  output logic             aspm_l11_en_o,
  output logic      [34:0] snoop_lat_ns_o,
  output logic      [34:0] nosnoop_lat_ns_o
);

  typedef struct packed {
    logic [9:0]  snp_val;
    logic [2:0]  snp_scl;
    logic [9:0]  nsnp_val;
    logic [2:0]  nsnp_scl;
    logic        pm_en;
    logic        aspm_en;
    logic        ack;
    logic        miss;
    logic [31:0] rdata;
    logic [34:0] snp_ns;
    logic [34:0] nsnp_ns;
  } lsr_state_t;

  lsr_state_t cur;
  lsr_state_t next_cur;

  logic [4:0]  cap_bits;
  logic [7:0]  ltssm_word;
  logic [15:0] slot_word;
  logic [34:0] snp_ns_calc;
  logic [34:0] nsnp_ns_calc;
  logic [31:0] lat_new;
  logic [31:0] rd_word;

  // dword match; the two low address bits are ignored
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, lsr_pkg::OFF_LATENCY) || hit(a, lsr_pkg::OFF_CAP_HDR) ||
             hit(a, lsr_pkg::OFF_CAP)     || hit(a, lsr_pkg::OFF_CTRL1)   ||
             hit(a, lsr_pkg::OFF_CTRL2)   || hit(a, lsr_pkg::OFF_LTSSM)   ||
             hit(a, lsr_pkg::OFF_SLOT);
  endfunction

  // reserved positions are left zero by construction
  function automatic logic [31:0] lat_word(input lsr_state_t s);
    lat_word = 32'h0;
    lat_word[lsr_pkg::SNP_VAL_LSB  +: lsr_pkg::LTR_VAL_W] = s.snp_val;
    lat_word[lsr_pkg::SNP_SCL_LSB  +: lsr_pkg::LTR_SCL_W] = s.snp_scl;
    lat_word[lsr_pkg::NSNP_VAL_LSB +: lsr_pkg::LTR_VAL_W] = s.nsnp_val;
    lat_word[lsr_pkg::NSNP_SCL_LSB +: lsr_pkg::LTR_SCL_W] = s.nsnp_scl;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    merge_be = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge_be[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // support flags: defaults replaceable only from the management side
  lsr_ro_word #(
    .W    (lsr_pkg::CAP_W),
    .ADDR (lsr_pkg::OFF_CAP),
    .RST  (lsr_pkg::RST_CAP),
    .MASK (lsr_pkg::CAP_MASK)
  ) u_cap (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ld_i      (mgmt_ld_i),
    .ld_addr_i (mgmt_addr_i),
    .ld_data_i (mgmt_data_i),
    .val_o     (cap_bits)
  ); // R9 R10 R11 R12

  lsr_ro_word #(
    .W    (lsr_pkg::LTSSM_W),
    .ADDR (lsr_pkg::OFF_LTSSM),
    .RST  (lsr_pkg::RST_LTSSM),
    .MASK (lsr_pkg::LTSSM_MASK)
  ) u_ltssm (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ld_i      (mgmt_ld_i),
    .ld_addr_i (mgmt_addr_i),
    .ld_data_i (mgmt_data_i),
    .val_o     (ltssm_word)
  ); // R15

  lsr_ro_word #(
    .W    (lsr_pkg::SLOT_W),
    .ADDR (lsr_pkg::OFF_SLOT),
    .RST  (lsr_pkg::RST_SLOT),
    .MASK (lsr_pkg::SLOT_MASK)
  ) u_slot (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .ld_i      (mgmt_ld_i),
    .ld_addr_i (mgmt_addr_i),
    .ld_data_i (mgmt_data_i),
    .val_o     (slot_word)
  ); // R16

  lsr_ltr_scale u_snp_scale (
    .val_i   (cur.snp_val),
    .scale_i (cur.snp_scl),
    .ns_o    (snp_ns_calc)
  ); // R17

  lsr_ltr_scale u_nsnp_scale (
    .val_i   (cur.nsnp_val),
    .scale_i (cur.nsnp_scl),
    .ns_o    (nsnp_ns_calc)
  ); // R17

  // read multiplexer
  always_comb begin
    rd_word = 32'h0;
    if (hit(cfg_addr_i, lsr_pkg::OFF_LATENCY)) begin
      rd_word = lat_word(cur); // R5
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_CAP_HDR)) begin
      rd_word = lsr_pkg::CAP_HDR_VALUE; // R6 R7 R8
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_CAP)) begin
      rd_word = {27'h0, cap_bits};
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_CTRL1)) begin
      rd_word[lsr_pkg::CTRL_PM_BIT]   = cur.pm_en;
      rd_word[lsr_pkg::CTRL_ASPM_BIT] = cur.aspm_en;
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_CTRL2)) begin
      rd_word = lsr_pkg::CTRL2_VALUE;
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_LTSSM)) begin
      rd_word = {24'h0, ltssm_word};
    end else if (hit(cfg_addr_i, lsr_pkg::OFF_SLOT)) begin
      rd_word = {16'h0, slot_word};
    end
  end

  always_comb begin
    next_cur         = cur;
    lat_new          = merge_be(lat_word(cur), cfg_wdata_i, cfg_be_i);
    next_cur.ack     = cfg_req_i;
    next_cur.miss    = cfg_req_i && !mapped(cfg_addr_i);
    next_cur.snp_ns  = snp_ns_calc;
    next_cur.nsnp_ns = nsnp_ns_calc;
    if (cfg_req_i && cfg_wr_i) begin
      // write answers carry zero data; read-only targets ignore the data
      next_cur.rdata = 32'h0;
      if (hit(cfg_addr_i, lsr_pkg::OFF_LATENCY)) begin
        next_cur.snp_val  = lat_new[lsr_pkg::SNP_VAL_LSB  +: lsr_pkg::LTR_VAL_W]; // R1
        next_cur.snp_scl  = lat_new[lsr_pkg::SNP_SCL_LSB  +: lsr_pkg::LTR_SCL_W]; // R2
        next_cur.nsnp_val = lat_new[lsr_pkg::NSNP_VAL_LSB +: lsr_pkg::LTR_VAL_W]; // R3
        next_cur.nsnp_scl = lat_new[lsr_pkg::NSNP_SCL_LSB +: lsr_pkg::LTR_SCL_W]; // R4
      end else if (hit(cfg_addr_i, lsr_pkg::OFF_CTRL1) && cfg_be_i[0]) begin
        next_cur.pm_en   = cfg_wdata_i[lsr_pkg::CTRL_PM_BIT]; // R13
        next_cur.aspm_en = cfg_wdata_i[lsr_pkg::CTRL_ASPM_BIT]; // R14
      end
    end else if (cfg_req_i) begin
      next_cur.rdata = rd_word;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur          <= '0;
      cur.snp_val  <= lsr_pkg::RST_LTR_VAL;
      cur.snp_scl  <= lsr_pkg::RST_LTR_SCL;
      cur.nsnp_val <= lsr_pkg::RST_LTR_VAL;
      cur.nsnp_scl <= lsr_pkg::RST_LTR_SCL;
      cur.pm_en    <= lsr_pkg::RST_CTRL_EN;
      cur.aspm_en  <= lsr_pkg::RST_CTRL_EN;
    end else begin
      cur <= next_cur;
    end
  end

  assign cfg_ack_o        = cur.ack;
  assign cfg_miss_o       = cur.miss;
  assign cfg_rdata_o      = cur.rdata;
  // enables steer the link power logic; both link ends must set them
  assign pm_l11_en_o      = cur.pm_en; // R13
  assign aspm_l11_en_o    = cur.aspm_en; // R14
  assign snoop_lat_ns_o   = cur.snp_ns;
  assign nosnoop_lat_ns_o = cur.nsnp_ns;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  logic cap_loaded;
  logic cfg_rd;
  logic cfg_wr;

  assign cfg_rd = cfg_req_i && !cfg_wr_i;
  assign cfg_wr = cfg_req_i && cfg_wr_i;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_loaded <= 1'b0;
    end else if (mgmt_ld_i && hit(mgmt_addr_i, lsr_pkg::OFF_CAP)) begin
      cap_loaded <= 1'b1;
    end
  end

  a_snoop_value: assert property ( // R1
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY) && (cfg_be_i[1:0] == 2'h3)
    |=> cur.snp_val == $past(cfg_wdata_i[9:0]))
    else $error("snoop latency value not written");

  a_snoop_scale: assert property ( // R2
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY) && cfg_be_i[1]
    |=> cur.snp_scl == $past(cfg_wdata_i[12:10]))
    else $error("snoop latency scale not written");

  a_nosnoop_value: assert property ( // R3
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY) && (cfg_be_i[3:2] == 2'h3)
    |=> cur.nsnp_val == $past(cfg_wdata_i[25:16]))
    else $error("no-snoop latency value not written");

  a_nosnoop_scale: assert property ( // R4
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY) && cfg_be_i[3]
    |=> cur.nsnp_scl == $past(cfg_wdata_i[28:26]))
    else $error("no-snoop latency scale not written");

  a_latency_reserved: assert property ( // R5
    cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY)
    |=> cfg_ack_o && (cfg_rdata_o[15:13] == 3'h0) && (cfg_rdata_o[31:29] == 3'h0))
    else $error("latency reserved bits not zero");

  a_header_value: assert property ( // R6 R7 R8
    cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_CAP_HDR)
    |=> cfg_ack_o && (cfg_rdata_o == 32'h0001_001E))
    else $error("capability header wrong");

  a_cap_defaults: assert property ( // R9 R10 R11
    cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_CAP) && !cap_loaded && !mgmt_ld_i
    |=> cfg_rdata_o == 32'h0000_0012)
    else $error("capability defaults wrong");

  a_cap_readonly: assert property ( // R12
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_CAP) && !mgmt_ld_i
    |=> $stable(cap_bits))
    else $error("capability changed by configuration write");

  a_cap_mgmt_load: assert property ( // R12
    mgmt_ld_i && hit(mgmt_addr_i, lsr_pkg::OFF_CAP)
    |=> cap_bits == ($past(mgmt_data_i[4:0]) & 5'h1A))
    else $error("capability not loaded from management path");

  a_enable_write: assert property ( // R13 R14
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_CTRL1) && cfg_be_i[0]
    |=> (pm_l11_en_o == $past(cfg_wdata_i[1])) && (aspm_l11_en_o == $past(cfg_wdata_i[3])))
    else $error("substates enables not written");

  a_ltssm_load: assert property ( // R15
    (mgmt_ld_i && hit(mgmt_addr_i, lsr_pkg::OFF_LTSSM))
    ##1 (cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_LTSSM) && !mgmt_ld_i)
    |=> cfg_rdata_o == {24'h0, $past(mgmt_data_i[7:0], 2)})
    else $error("link training word not loaded");

  a_slot_load: assert property ( // R16
    (mgmt_ld_i && hit(mgmt_addr_i, lsr_pkg::OFF_SLOT))
    ##1 (cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_SLOT) && !mgmt_ld_i)
    |=> cfg_rdata_o == {16'h0, $past(mgmt_data_i[15:0], 2)})
    else $error("slot change word not loaded");

  a_scale_unit: assert property ( // R17
    (cur.snp_scl == 3'h0) |=> snoop_lat_ns_o == {25'h0, $past(cur.snp_val)})
    else $error("scale code zero not one ns");

  a_scale_kilo: assert property ( // R17
    (cur.nsnp_scl == 3'h2) |=> nosnoop_lat_ns_o == {15'h0, $past(cur.nsnp_val), 10'h0})
    else $error("scale code two not 1024 ns");

  a_ack_timing: assert property (
    cfg_req_i |=> cfg_ack_o ##1 (cfg_ack_o == $past(cfg_req_i)))
    else $error("answer not one cycle after request");

  c_latency_write: cover property (
    cfg_wr && hit(cfg_addr_i, lsr_pkg::OFF_LATENCY) && (cfg_be_i == 4'hF));
  c_header_read: cover property (
    cfg_rd && hit(cfg_addr_i, lsr_pkg::OFF_CAP_HDR));
  c_cap_override: cover property (
    mgmt_ld_i && hit(mgmt_addr_i, lsr_pkg::OFF_CAP));
  c_pm_enabled: cover property ($rose(pm_l11_en_o));

endmodule

// ===== testbench/lsr_tb.sv
/*
  Self-checking bench for the latency-tolerance and L1 PM substates slice.
  Assumes the design files and lsr_pkg are compiled first; the bench drives
  every input at the falling edge of a 10 MHz core clock.
*/
`timescale 1ns/1ps
module testbench;
  logic        sys_clk;
  logic        nrst;
  logic        cfg_req;
  logic        cfg_wr;
  logic [11:0] cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic        cfg_ack;
  logic        cfg_miss;
  logic [31:0] cfg_rdata;
  logic        mgmt_ld;
  logic [11:0] mgmt_addr;
  logic [31:0] mgmt_data;
  logic        pm_en;
  logic        aspm_en;
  logic [34:0] snp_ns;
  logic [34:0] nsnp_ns;
  logic [31:0] rd;
  logic        ms;
  int          n_fail;
  int          checked;
  logic [11:0] ro_addr [7];
  logic [31:0] ro_rst  [7];

  lsr_ltr_l1_regs lsr_ltr_l1_regs_i (
    .sys_clk_i       (sys_clk),
    .nrst_i          (nrst),
    .cfg_req_i       (cfg_req),
    .cfg_wr_i        (cfg_wr),
    .cfg_addr_i      (cfg_addr),
    .cfg_be_i        (cfg_be),
    .cfg_wdata_i     (cfg_wdata),
    .cfg_ack_o       (cfg_ack),
    .cfg_miss_o      (cfg_miss),
    .cfg_rdata_o     (cfg_rdata),
    .mgmt_ld_i       (mgmt_ld),
    .mgmt_addr_i     (mgmt_addr),
    .mgmt_data_i     (mgmt_data),
    .pm_l11_en_o     (pm_en),
    .aspm_l11_en_o   (aspm_en),
    .snoop_lat_ns_o  (snp_ns),
    .nosnoop_lat_ns_o(nsnp_ns)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_ns(input string what, input logic [34:0] exp, input logic [34:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered and left at a falling edge; request held over exactly one rising edge
  task automatic cfg_acc(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                         input logic [31:0] wd);
    cfg_req   = 1'b1;
    cfg_wr    = wr;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = wd;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cfg_req = 1'b0;
    check_bit("ack", 1'b1, cfg_ack);
    rd = cfg_rdata;
    ms = cfg_miss;
    // idle cycle: the next call never retoggles the strobe in one step, ack has dropped
    @(negedge sys_clk);
  endtask

  task automatic wr_reg(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd);
    cfg_acc(1'b1, addr, be, wd);
    check_word("write ack data", 32'h0000_0000, rd);
  endtask

  task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
    cfg_acc(1'b0, addr, 4'h0, 32'hA5A5_5A5A);
    check_word("read data", exp, rd);
    check_bit("miss", 1'b0, ms);
  endtask

  task automatic mgmt_load(input logic [11:0] addr, input logic [31:0] d);
    mgmt_ld   = 1'b1;
    mgmt_addr = addr;
    mgmt_data = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    mgmt_ld   = 1'b0;
    mgmt_data = ~d;
  endtask

  function automatic logic [34:0] exp_ns(input logic [9:0] v, input logic [2:0] s);
    if (s > 3'h5) begin
      return 35'h0;
    end
    return {25'h0, v} << (5 * s);
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    cfg_req = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
    mgmt_ld = 1'b0;
    mgmt_addr = 12'h000;
    mgmt_data = 32'h0000_0000;
    ro_addr = '{12'h234, 12'h240, 12'h244, 12'h248, 12'h24C, 12'h33C, 12'h340};
    ro_rst  = '{32'h0, 32'h0001_001E, 32'h0000_0012, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    // reset values of every mapped word
    foreach (ro_addr[i]) begin
      rd_chk(ro_addr[i], ro_rst[i]);
    end
    check_bit("ack one cycle", 1'b0, cfg_ack);
    check_bit("pm enable", 1'b0, pm_en);
    check_bit("aspm enable", 1'b0, aspm_en);
    // reserved latency bits stay zero, byte enables honoured
    wr_reg(12'h234, 4'hF, 32'hFFFF_FFFF);
    rd_chk(12'h234, 32'h1FFF_1FFF);
    wr_reg(12'h234, 4'h5, 32'h0000_0000);
    rd_chk(12'h234, 32'h1F00_1F00);
    // every scale code on both limits
    for (int s = 0; s < 8; s++) begin
      wr_reg(12'h234, 4'hF, {3'h0, 3'(7 - s), 10'h2A5, 3'h0, 3'(s), 10'h3FF});
      @(negedge sys_clk);
      check_ns("snoop ns", exp_ns(10'h3FF, 3'(s)), snp_ns);
      check_ns("nosnoop ns", exp_ns(10'h2A5, 3'(7 - s)), nsnp_ns);
    end
    // read-only words ignore configuration writes
    for (int i = 1; i < 7; i++) begin
      if (ro_addr[i] != 12'h248) begin
        wr_reg(ro_addr[i], 4'hF, 32'hFFFF_FFFF);
        rd_chk(ro_addr[i], ro_rst[i]);
      end
    end
    // enables
    wr_reg(12'h248, 4'hF, 32'hFFFF_FFFF);
    rd_chk(12'h248, 32'h0000_000A);
    check_bit("pm enable", 1'b1, pm_en);
    check_bit("aspm enable", 1'b1, aspm_en);
    wr_reg(12'h248, 4'h1, 32'h0000_0002);
    check_bit("pm enable", 1'b1, pm_en);
    check_bit("aspm enable", 1'b0, aspm_en);
    wr_reg(12'h248, 4'hE, 32'h0000_0000);
    rd_chk(12'h248, 32'h0000_0002);
    // management path replaces read-only defaults only
    mgmt_load(12'h244, 32'hFFFF_FFEF);
    rd_chk(12'h244, 32'h0000_000A);
    mgmt_load(12'h244, 32'h0000_0010);
    rd_chk(12'h244, 32'h0000_0010);
    mgmt_load(12'h33C, 32'h1234_56A5);
    rd_chk(12'h33C, 32'h0000_00A5);
    mgmt_load(12'h340, 32'h1234_ABCD);
    rd_chk(12'h340, 32'h0000_ABCD);
    wr_reg(12'h234, 4'hF, 32'h0000_0000);
    mgmt_load(12'h234, 32'hFFFF_FFFF);
    // let an edge pass so the load strobe is not raised where it was just lowered
    @(negedge sys_clk);
    mgmt_load(12'h248, 32'hFFFF_FFFF);
    rd_chk(12'h234, 32'h0000_0000);
    rd_chk(12'h248, 32'h0000_0002);
    // unmapped addresses
    cfg_acc(1'b0, 12'h238, 4'h0, 32'h0);
    check_word("unmapped data", 32'h0000_0000, rd);
    check_bit("unmapped miss", 1'b1, ms);
    cfg_acc(1'b1, 12'h344, 4'hF, 32'hFFFF_FFFF);
    check_bit("unmapped miss", 1'b1, ms);
    // second reset restores defaults, including loaded ones
    wr_reg(12'h234, 4'hF, 32'h0C01_0401);
    nrst = 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check_ns("snoop ns in reset", 35'h0, snp_ns);
    nrst = 1'b1;
    foreach (ro_addr[i]) rd_chk(ro_addr[i], ro_rst[i]);
    check_bit("pm enable", 1'b0, pm_en);
    complete_run();
  end
endmodule
